// ### design/ppc_clock_frame_select.sv
// clock and frame-sync selection for the byte-wide parallel tdm port
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_consts.svh"

module ppc_clock_frame_select (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // parallel port pins
  input  wire logic        receive_parallel_clock,
  input  wire logic        transmit_parallel_clock,
  input  wire logic        receive_frame_pulse,
  input  wire logic [7:0]  receive_byte_lines,
  output logic      [7:0]  transmit_byte_lines,
  output logic      [3:0]  external_control_lines,
  input  wire logic        transmit_frame_sync_in,
  output logic             transmit_frame_sync_out,
  output logic             transmit_frame_sync_oe_n,
  // serial clock pins
  input  wire logic        serial_reference_input_a,
  input  wire logic        serial_reference_input_b,
  output logic             serial_shift_clock_out,
  output logic             serial_shift_clock_oe_n,
  output logic             serial_frame_out,
  // user side
  input  wire logic [7:0]  tx_byte_in,
  input  wire logic [3:0]  tx_control_in,
  output logic             tx_byte_taken,
  output logic      [7:0]  rx_byte_out,
  output logic             rx_byte_valid,
  output logic             rx_frame_start
);

  ppc_pkg::ppc_state_s r_reg;
  ppc_pkg::ppc_state_s r_next;
  logic [1:0]          rst_pipe_reg;
  logic                rst_sync_n;
  logic                rx_edge;
  logic                tx_edge;
  logic                launch;
  logic                realign;
  logic                sck_src;
  logic                ser_rise;
  logic [11:0]         last_idx;

  // serial clock is only produced in timing modes two and three
  function automatic logic serial_mode(input ppc_pkg::ppc_mode_e m);
    serial_mode = (m == ppc_pkg::ppc_timing_mode_two) ||
                  (m == ppc_pkg::ppc_timing_mode_three);
  endfunction

  // parallel clock cycles per frame for the programmed rate
  function automatic logic [11:0] frame_len(input logic [1:0] rate);
    if (rate == `PPC_RATE_16M384) begin
      frame_len = `PPC_FRAME_LEN_16M384;
    end else if (rate == `PPC_RATE_6M48) begin
      frame_len = `PPC_FRAME_LEN_6M48;
    end else begin
      frame_len = `PPC_FRAME_LEN_19M44;
    end
  endfunction

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_reg[1];

  // edges of the sampled parallel clocks, from stage two and three only
  assign rx_edge = r_reg.sync_b[`PPC_PIN_RXCLK] &
                   ~r_reg.sync_c[`PPC_PIN_RXCLK];
  assign tx_edge = r_reg.sync_b[`PPC_PIN_TXCLK] &
                   ~r_reg.sync_c[`PPC_PIN_TXCLK];

  // transmit launch clock: own clock in mode one, else receive clock
  assign launch = (r_reg.mode == ppc_pkg::ppc_timing_mode_one) ?
                  tx_edge :
                  rx_edge;

  // frame reference that restarts the transmit frame counter
  always_comb begin
    if (r_reg.mode == ppc_pkg::ppc_timing_mode_three) begin
      realign = r_reg.sync_b[`PPC_PIN_RXFP];
    end else if (r_reg.fdi) begin
      realign = r_reg.sync_b[`PPC_PIN_TFS];
    end else begin
      realign = 1'b0;
    end
  end

  // serial reference choice; internal clock overrides both inputs
  always_comb begin
    if (r_reg.internal_clock_select) begin
      sck_src = r_reg.nco[31];
    end else if (r_reg.refsel) begin
      sck_src = r_reg.sync_b[`PPC_PIN_REFA];
    end else begin
      sck_src = r_reg.sync_b[`PPC_PIN_REFB];
    end
  end

  assign ser_rise = serial_mode(r_reg.mode) && sck_src && !r_reg.sck;
  assign last_idx = 12'(frame_len(r_reg.rate) - 12'h001);

  // next state for every register of the block but the reset synchroniser
  always_comb begin
    r_next = r_reg;
    r_next.rdata = 32'h00000000;
    // pins from other clocks pass two flops before any logic
    r_next.sync_a = {serial_reference_input_b, serial_reference_input_a,
                     transmit_frame_sync_in, receive_frame_pulse,
                     transmit_parallel_clock, receive_parallel_clock,
                     receive_byte_lines};
    r_next.sync_b = r_reg.sync_a;
    r_next.sync_c = r_reg.sync_b;

    // register writes steer mode, direction and reference choice
    if (reg_write && reg_addr == `PPC_ADDR_CTRL) begin
      r_next.mode   = ppc_pkg::ppc_mode_e'(
                        reg_wdata[`PPC_CTRL_MODE_HI:`PPC_CTRL_MODE_LO]);
      r_next.fdi    = reg_wdata[`PPC_CTRL_FDI_BIT];
      r_next.refsel = reg_wdata[`PPC_CTRL_REFSEL_BIT];
      r_next.internal_clock_select = reg_wdata[`PPC_CTRL_INTERNAL_CLOCK_SELECT_BIT];
      r_next.rate   = reg_wdata[`PPC_CTRL_RATE_HI:`PPC_CTRL_RATE_LO];
    end

    // register reads answer one cycle later, unmapped reads give zero
    if (reg_read) begin
      if (reg_addr == `PPC_ADDR_CTRL) begin
        r_next.rdata = {25'h0000000, r_reg.rate, r_reg.internal_clock_select,
                        r_reg.refsel, r_reg.fdi, r_reg.mode};
      end else if (reg_addr == `PPC_ADDR_STATUS) begin
        r_next.rdata = {16'h0000, 1'b0, r_reg.ser_frame,
                        ~serial_shift_clock_oe_n,
                        ~transmit_frame_sync_oe_n, r_reg.tx_cnt};
      end
    end

    // receive side capture on the receive clock
    r_next.rx_valid = 1'b0;
    r_next.rx_frame = 1'b0;
    if (rx_edge) begin
      r_next.rx_byte  = r_reg.sync_b[7:0];
      r_next.rx_valid = 1'b1;
      r_next.rx_frame = r_reg.sync_b[`PPC_PIN_RXFP];
    end

    // transmit launch and frame counting
    if (launch) begin
      r_next.tx_byte = tx_byte_in;
      r_next.ctl     = tx_control_in;
      if (realign || r_reg.tx_cnt >= last_idx) begin
        r_next.tx_cnt = 12'h000;
      end else begin
        r_next.tx_cnt = 12'(r_reg.tx_cnt + 12'h001);
      end
      r_next.tfs_out = (r_next.tx_cnt == 12'h000);
    end

    // internal 4.096 mhz reference by phase accumulation
    r_next.nco = 32'(r_reg.nco + `PPC_NCO_STEP);

    // serial clock and frame; clock idles low outside modes two and three
    if (serial_mode(r_reg.mode)) begin
      r_next.sck = sck_src;
    end else begin
      r_next.sck = 1'b0;
    end
    // with an external reference in mode two the serial frame count restarts at the transmit frame start
    if (r_reg.mode == ppc_pkg::ppc_timing_mode_two && !r_reg.internal_clock_select &&
        launch && r_next.tx_cnt == 12'h000) begin
      r_next.ser_cnt   = 9'h000;
      r_next.ser_frame = 1'b0;
    end else if (ser_rise) begin
      r_next.ser_frame = (r_reg.ser_cnt == `PPC_SER_LAST);
      r_next.ser_cnt   = 9'(r_reg.ser_cnt + 9'h001);
    end
  end

  // the state register of the block, apart from the reset synchroniser
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      r_reg <= ppc_pkg::ppc_state_s'(0);
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs; enables are active low and release the pin when high
  assign reg_rdata               = r_reg.rdata;
  assign transmit_byte_lines     = r_reg.tx_byte;
  assign external_control_lines  = r_reg.ctl;
  assign transmit_frame_sync_out = r_reg.tfs_out;
  assign transmit_frame_sync_oe_n =
    r_reg.fdi ||
    (r_reg.mode == ppc_pkg::ppc_timing_mode_three);
  assign serial_shift_clock_out  = r_reg.sck;
  assign serial_shift_clock_oe_n = !serial_mode(r_reg.mode);
  // at 8.192 mbps the system feeds the serial clock on a reference pin
  assign serial_frame_out        = r_reg.ser_frame;
  assign tx_byte_taken           = launch;
  assign rx_byte_out             = r_reg.rx_byte;
  assign rx_byte_valid           = r_reg.rx_valid;
  assign rx_frame_start          = r_reg.rx_frame;

  // checks kept beside the logic they guard
  a_tfs_input_dir: assert property (@(posedge clock) disable iff (!rst_sync_n)
    r_reg.fdi |-> transmit_frame_sync_oe_n)
    else $error("frame sync driven while set as input");
  a_tfs_mode_three: assert property (@(posedge clock)
    disable iff (!rst_sync_n)
    (r_reg.mode == ppc_pkg::ppc_timing_mode_three)
    |-> transmit_frame_sync_oe_n)
    else $error("frame sync driven in mode three");
  a_sck_float_mode: assert property (@(posedge clock)
    disable iff (!rst_sync_n)
    (r_reg.mode == ppc_pkg::ppc_timing_mode_one ||
     r_reg.mode == ppc_pkg::ppc_timing_mode_four)
    |-> serial_shift_clock_oe_n)
    else $error("serial clock driven in mode one or four");
  a_rx_byte_capture: assert property (@(posedge clock)
    disable iff (!rst_sync_n)
    rx_edge |=> rx_byte_valid &&
    rx_byte_out == $past(r_reg.sync_b[7:0]))
    else $error("receive byte not captured on receive clock");
  a_rx_frame_mark: assert property (@(posedge clock)
    disable iff (!rst_sync_n)
    (rx_edge && r_reg.sync_b[`PPC_PIN_RXFP]) |=> rx_frame_start)
    else $error("receive frame start missed");
  a_tx_mode_one: assert property (@(posedge clock)
    disable iff (!rst_sync_n)
    (r_reg.mode == ppc_pkg::ppc_timing_mode_one && tx_edge)
    |=> transmit_byte_lines == $past(tx_byte_in))
    else $error("byte not launched on transmit clock");
  a_tx_clock_ignored: assert property (@(posedge clock)
    disable iff (!rst_sync_n)
    (r_reg.mode != ppc_pkg::ppc_timing_mode_one && !rx_edge)
    |=> $stable(transmit_byte_lines) && $stable(r_reg.tx_cnt))
    else $error("transmit port moved without receive clock");
  a_rx_clock_drives: assert property (@(posedge clock)
    disable iff (!rst_sync_n)
    (r_reg.mode != ppc_pkg::ppc_timing_mode_one && rx_edge)
    |=> transmit_byte_lines == $past(tx_byte_in))
    else $error("receive clock did not launch transmit byte");
  a_mode_three_sync: assert property (@(posedge clock)
    disable iff (!rst_sync_n)
    (r_reg.mode == ppc_pkg::ppc_timing_mode_three && rx_edge &&
     r_reg.sync_b[`PPC_PIN_RXFP]) |=> r_reg.tx_cnt == 12'h000)
    else $error("mode three transmit frame not on receive pulse");
  a_cascade_realign: assert property (@(posedge clock)
    disable iff (!rst_sync_n)
    (r_reg.fdi && r_reg.mode != ppc_pkg::ppc_timing_mode_three &&
     launch && r_reg.sync_b[`PPC_PIN_TFS])
    |=> r_reg.tx_cnt == 12'h000 && transmit_frame_sync_out)
    else $error("transmit counter not realigned to input pulse");
  a_frame_sync_mark: assert property (@(posedge clock)
    disable iff (!rst_sync_n)
    launch |=> transmit_frame_sync_out == (r_reg.tx_cnt == 12'h000))
    else $error("frame sync not at frame start");

endmodule

`default_nettype wire

// ### design/ppc_consts.svh
// register offsets, field positions, reset values and frame counts
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH

// register byte addresses on the plain register port
`define PPC_ADDR_CTRL        8'h00
`define PPC_ADDR_STATUS      8'h04

// control register fields
`define PPC_CTRL_MODE_LO     0
`define PPC_CTRL_MODE_HI     1
`define PPC_CTRL_FDI_BIT     2
`define PPC_CTRL_REFSEL_BIT  3
`define PPC_CTRL_INTERNAL_CLOCK_SELECT_BIT  4
`define PPC_CTRL_RATE_LO     5
`define PPC_CTRL_RATE_HI     6
`define PPC_CTRL_RESET       32'h00000000

// parallel clock rate codes
`define PPC_RATE_19M44       2'h0
`define PPC_RATE_16M384      2'h1
`define PPC_RATE_6M48        2'h2

// parallel clock cycles per 8 kHz frame at each rate
`define PPC_FRAME_LEN_19M44  12'h97E
`define PPC_FRAME_LEN_16M384 12'h800
`define PPC_FRAME_LEN_6M48   12'h32A

// serial clock cycles per frame at 4.096 MHz, last index
`define PPC_SER_LAST         9'h1FF

// phase step for 4.096 MHz from 50 MHz: 4.096 / 50 * 2^32
`define PPC_NCO_STEP         32'h14F8B589

// synchroniser bit positions within the sampled pin vector
`define PPC_PIN_RXCLK        8
`define PPC_PIN_TXCLK        9
`define PPC_PIN_RXFP         10
`define PPC_PIN_TFS          11
`define PPC_PIN_REFA         12
`define PPC_PIN_REFB         13
`define PPC_PIN_W            14

`endif

// ### design/ppc_pkg.sv
// types for the parallel port clock and frame select block
package ppc_pkg;

  typedef enum logic [1:0] {
    ppc_timing_mode_one,
    ppc_timing_mode_two,
    ppc_timing_mode_three,
    ppc_timing_mode_four
  } ppc_mode_e;

  typedef struct packed {
    logic [13:0] sync_a;     // first synchroniser stage
    logic [13:0] sync_b;     // second stage
    logic [13:0] sync_c;     // previous second stage, for edges
    ppc_mode_e   mode;
    logic        fdi;
    logic        refsel;
    logic        internal_clock_select;
    logic [1:0]  rate;
    logic [7:0]  rx_byte;
    logic        rx_valid;
    logic        rx_frame;
    logic [11:0] tx_cnt;
    logic [7:0]  tx_byte;
    logic [3:0]  ctl;
    logic        tfs_out;
    logic [31:0] nco;
    logic        sck;
    logic [8:0]  ser_cnt;
    logic        ser_frame;
    logic [31:0] rdata;
  } ppc_state_s;

endpackage

// ### verif/ppc_far_model.sv
// far-side framer model: parallel clocks, frame pulse, bytes, serial refs
`timescale 1ns/1ps
`default_nettype none

module ppc_far_model #(
  parameter int FRAME_LEN = 810,
  parameter int RX_HALF   = 6,
  parameter int TX_HALF   = 9,
  parameter int A_HALF    = 5,
  parameter int B_HALF    = 10
) (
  // pacing clock
  input  wire logic       clock,
  // parallel port; all lines start low so nothing is unknown at time zero
  output logic            receive_parallel_clock   = 1'b0,
  output logic            transmit_parallel_clock  = 1'b0,
  output logic            receive_frame_pulse      = 1'b0,
  output logic      [7:0] receive_byte_lines       = 8'h00,
  // serial references
  output logic            serial_reference_input_a = 1'b0,
  output logic            serial_reference_input_b = 1'b0
);
  int rx_t = 0;
  int tx_t = 0;
  int a_t  = 0;
  int b_t  = 0;
  int idx  = 0;

  // byte and pulse move on the falling edge, steady for the rising capture
  always @(negedge clock) begin
    rx_t <= (rx_t + 1) % RX_HALF;
    if (rx_t == RX_HALF - 1) begin
      receive_parallel_clock <= !receive_parallel_clock;
      if (receive_parallel_clock) begin
        idx                 <= (idx + 1) % FRAME_LEN;
        receive_frame_pulse <= ((idx + 1) % FRAME_LEN) == 0;
        receive_byte_lines  <= 8'(idx) ^ 8'hA5;
      end
    end
  end

  // transmit clock and both references run free at rates of their own
  always @(negedge clock) begin
    tx_t <= (tx_t + 1) % TX_HALF;
    a_t  <= (a_t + 1) % A_HALF;
    b_t  <= (b_t + 1) % B_HALF;
    if (tx_t == TX_HALF - 1)
      transmit_parallel_clock <= !transmit_parallel_clock;
    if (a_t == A_HALF - 1)
      serial_reference_input_a <= !serial_reference_input_a;
    if (b_t == B_HALF - 1)
      serial_reference_input_b <= !serial_reference_input_b;
  end
endmodule

`default_nettype wire

// ### verif/tb_ppc_clock_frame_select.sv
// self-checking bench for the parallel port clock and frame select block
`timescale 1ns/1ps
`default_nettype none
`include "ppc_consts.svh"

module tb_ppc_clock_frame_select;
  logic        clock     = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic        transmit_frame_sync_in = 1'b0;
  logic [7:0]  tx_byte_in = 8'h00;
  logic [3:0]  tx_control_in = 4'h0;
  logic [31:0] seed = 32'h0000A945;
  logic [31:0] reg_rdata, d, w;
  logic        receive_parallel_clock, transmit_parallel_clock;
  logic        receive_frame_pulse, transmit_frame_sync_out;
  logic        serial_reference_input_a, serial_reference_input_b;
  logic        transmit_frame_sync_oe_n, serial_shift_clock_out;
  logic        serial_shift_clock_oe_n, tx_byte_taken;
  logic        rx_byte_valid, rx_frame_start, pend, serial_frame_out;
  logic [7:0]  receive_byte_lines, transmit_byte_lines, rx_byte_out, exp_b;
  logic [3:0]  external_control_lines, exp_c;
  int          n_errors, checks_done, cyc;
  int          n_take, n_rx, n_tx, n_a, n_b, n_sck, n_sfr;

  ppc_clock_frame_select i_ppc_clock_frame_select (
    .clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .receive_parallel_clock, .transmit_parallel_clock,
    .receive_frame_pulse, .receive_byte_lines, .transmit_byte_lines,
    .external_control_lines, .transmit_frame_sync_in,
    .transmit_frame_sync_out, .transmit_frame_sync_oe_n,
    .serial_reference_input_a, .serial_reference_input_b,
    .serial_shift_clock_out, .serial_shift_clock_oe_n,
    .serial_frame_out, .tx_byte_in, .tx_control_in, .tx_byte_taken,
    .rx_byte_out, .rx_byte_valid, .rx_frame_start
  );

  ppc_far_model i_ppc_far_model (
    .clock, .receive_parallel_clock, .transmit_parallel_clock,
    .receive_frame_pulse, .receive_byte_lines,
    .serial_reference_input_a, .serial_reference_input_b
  );

  always #10 clock = !clock;

  // edge counters for the rate comparisons
  always @(posedge receive_parallel_clock) n_rx++;
  always @(posedge transmit_parallel_clock) n_tx++;
  always @(posedge serial_reference_input_a) n_a++;
  always @(posedge serial_reference_input_b) n_b++;
  always @(posedge serial_shift_clock_out) n_sck++;
  always @(posedge serial_frame_out) n_sfr++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // a window edge may split one period, so allow one edge either way
  function automatic logic near(int a, int b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction

  function automatic logic [31:0] ctrl(int m, int f, int r, int i, int t);
    return 32'(m) | 32'(f) << `PPC_CTRL_FDI_BIT
         | 32'(r) << `PPC_CTRL_REFSEL_BIT | 32'(i) << `PPC_CTRL_INTERNAL_CLOCK_SELECT_BIT
         | 32'(t) << `PPC_CTRL_RATE_LO;
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // a spare edge after each strobe keeps strobes from being set twice
  task automatic wr(logic [7:0] a, logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
    @(negedge clock);
    check("rdata_idle", reg_rdata, 32'h00000000);
    @(posedge clock);
  endtask

  task automatic window(int len);
    n_take = 0;
    n_rx   = 0;
    n_tx   = 0;
    n_a    = 0;
    n_b    = 0;
    n_sck  = 0;
    n_sfr  = 0;
    repeat (len) @(posedge clock);
  endtask

  task automatic wait_fs(logic v);
    int k;
    @(negedge clock);
    for (k = 0; k < 12000 && transmit_frame_sync_out !== v; k++)
      @(negedge clock);
    @(posedge clock);
  endtask

  // random user data reaches the transmit side every cycle
  always @(posedge clock) begin
    tx_byte_in    <= 8'(rnd());
    tx_control_in <= 4'(rnd());
    cyc++;
    if (cyc == 100000) begin
      n_errors++;
      results();
    end
  end

  // capture and launch checks mid-cycle, where outputs have settled
  always @(negedge clock) begin
    if (rst_n && rx_byte_valid === 1'b1) begin
      check("rx_byte", 32'(rx_byte_out), 32'(receive_byte_lines));
      check("rx_frame", 32'(rx_frame_start), 32'(receive_frame_pulse));
    end
    if (pend) begin
      check("tx_byte", 32'(transmit_byte_lines), 32'(exp_b));
      check("tx_ctl", 32'(external_control_lines), 32'(exp_c));
    end
    pend = rst_n && tx_byte_taken === 1'b1;
    if (pend)
      n_take++;
    exp_b = tx_byte_in;
    exp_c = tx_control_in;
  end

  initial begin
    int m;
    int k;
    int e;
    repeat (5) @(posedge clock);
    check("fs_oe_rst", 32'(transmit_frame_sync_oe_n), 32'h0);
    check("sck_oe_rst", 32'(serial_shift_clock_oe_n), 32'h1);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(`PPC_ADDR_CTRL, d);
    check("ctrl_rst", d, `PPC_CTRL_RESET);
    // random control words read back; other addresses leave it alone
    for (k = 0; k < 4; k++) begin
      w = rnd() & 32'h0000007F;
      wr(`PPC_ADDR_CTRL, w);
      rd(`PPC_ADDR_CTRL, d);
      check("ctrl_rb", d & 32'h0000007F, w);
    end
    wr(`PPC_ADDR_STATUS, 32'hFFFFFFFF);
    wr(8'h08, 32'h00000000);
    rd(`PPC_ADDR_CTRL, d);
    check("ctrl_keep", d & 32'h0000007F, w);
    rd(8'h08, d);
    check("unmapped", d, 32'h00000000);
    // every timing mode: launching clock and which pins are driven
    for (m = 0; m < 4; m++) begin
      wr(`PPC_ADDR_CTRL, ctrl(m, 0, 1, 0, 2));
      repeat (40) @(posedge clock);
      window(1200);
      e = (m == 0) ? n_tx : n_rx;
      check("sck_oe", 32'(serial_shift_clock_oe_n), 32'(m == 0 || m == 3));
      check("fs_oe", 32'(transmit_frame_sync_oe_n), 32'(m == 2));
      check("launches", 32'(near(n_take, e)), 32'h1);
      if (m == 1 || m == 2)
        check("sck_a", 32'(near(n_sck, n_a)), 32'h1);
    end
    // reference choice for the generated serial clock in mode two
    for (k = 0; k < 4; k++) begin
      wr(`PPC_ADDR_CTRL, ctrl(1, 0, k & 1, k >> 1, 2));
      repeat (40) @(posedge clock);
      window(2000);
      e = (k > 1) ? 2000 * 4096 / 50000 : ((k == 1) ? n_a : n_b);
      check("sck_src", 32'(near(n_sck, e)), 32'h1);
    end
    // transmit frame length at the slowest rate
    wr(`PPC_ADDR_CTRL, ctrl(1, 0, 1, 0, 2));
    wait_fs(1'b1);
    n_take = 0;
    wait_fs(1'b0);
    wait_fs(1'b1);
    check("frame_len", 32'(n_take), 32'(`PPC_FRAME_LEN_6M48));
    // mode three: receive frame pulse restarts the transmit frame
    wr(`PPC_ADDR_CTRL, ctrl(2, 0, 1, 0, 2));
    @(negedge clock);
    for (k = 0; k < 12000 && rx_frame_start !== 1'b1; k++)
      @(negedge clock);
    @(posedge clock);
    rd(`PPC_ADDR_STATUS, d);
    check("realign_rx", 32'(d[11:0] <= 12'h001), 32'h1);
    // internal reference: one serial frame pulse every 512 serial clocks
    wr(`PPC_ADDR_CTRL, ctrl(1, 0, 1, 1, 2));
    window(12600);
    e = 12600 * 4096 / 50000 / 512;
    check("ser_frame", 32'(near(n_sfr, e)), 32'h1);
    // frame sync as input: a pulse on the pin restarts the count
    wr(`PPC_ADDR_CTRL, ctrl(0, 1, 1, 0, 2));
    check("fs_oe_in", 32'(transmit_frame_sync_oe_n), 32'h1);
    repeat (200) @(posedge clock);
    transmit_frame_sync_in <= 1'b1;
    repeat (20) @(posedge clock);
    transmit_frame_sync_in <= 1'b0;
    rd(`PPC_ADDR_STATUS, d);
    check("realign_in", 32'(d[11:0] <= 12'h002), 32'h1);
    check("fs_drv", 32'(d[12]), 32'h0);
    results();
  end
endmodule

`default_nettype wire
